/* verilog/rflw_monitor.sv */
`timescale 1ns/10ps
// Functional notes
// [R1] reference-low warns while the remote reference is below a low limit bounded below by -999,999.999.
// [R2] reference-high warns while the resulting reference exceeds a high limit capped at 999,999.999.
// [R3] feedback-low warns while feedback is below a low limit that cannot pass the high one.
// [R4] feedback-high warns while feedback exceeds a high limit capped at 999,999.999.
// [R5] all warnings stay off during ramp-up, ramp-down and while stopped.
// [R6] warnings are evaluated only after the output has reached the reference.
// [R7] each warning can be routed to the signal outputs and the relay outputs.
// [R8] reference limits count only while the remote reference is selected.
// [R9] the high feedback limit is held between the low feedback limit and 999,999.999.
// [R10] restoring defaults puts the reference limits at +/-999,999.999.
// [R11] reference limits are in hertz in open loop and process units in closed loop.
// [R12] selector value 0 is open loop and value 1 is closed loop.
// [R13] comparisons are strict and a warning drops as soon as its cause is gone.
module rflw_monitor (
  // clock and reset
  input  wire logic                                 mclk_in,
  input  wire logic                                 srst_in,
  // apb slave
  input  wire logic                                 psel_in,
  input  wire logic                                 penable_in,
  input  wire logic                                 pwrite_in,
  input  wire logic [rflw_pkg::ADDR_W-1:0]          paddr_in,
  input  wire logic [rflw_pkg::DATA_W-1:0]          pwdata_in,
  output logic      [rflw_pkg::DATA_W-1:0]          prdata_out,
  output logic                                      pready_out,
  output logic                                      pslverr_out,
  // drive state
  input  wire logic                                 run_cmd_in,
  input  wire logic                                 at_ref_in,
  input  wire logic                                 drive_stopped_in,
  // monitored values
  input  wire logic signed [rflw_pkg::DATA_W-1:0]   remote_ref_in,
  input  wire logic signed [rflw_pkg::DATA_W-1:0]   result_ref_in,
  input  wire logic signed [rflw_pkg::DATA_W-1:0]   feedback_in,
  // warnings and routed outputs
  output logic      [rflw_pkg::NUM_WARN-1:0]        warn_out,
  output logic      [rflw_pkg::NUM_SIG_OUT-1:0]     sig_out,
  output logic      [rflw_pkg::NUM_RELAY-1:0]       relay_out,
  output logic                                      unit_hz_out
);

  localparam int DW = rflw_pkg::DATA_W;
  localparam int NW = rflw_pkg::NUM_WARN;

  // --------------------------------------------------------------------------
  // limit clamp
  // --------------------------------------------------------------------------
  function automatic logic signed [DW-1:0] clamp(input logic signed [DW-1:0] v,
                                                 input logic signed [DW-1:0] lo,
                                                 input logic signed [DW-1:0] hi);
    logic signed [DW-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // apb access
  // --------------------------------------------------------------------------
  rflw_pkg::rflw_loop_t  loop_mode;
  logic                  remote_sel;
  logic [DW-1:0]         route;
  logic signed [DW-1:0]  ref_low;
  logic signed [DW-1:0]  ref_high;
  logic signed [DW-1:0]  feedback_low_limit;
  logic signed [DW-1:0]  feedback_high_limit;
  logic [DW-1:0]         rd_word;
  logic                  addr_hit;
  logic [DW-1:0]         status_word;
  logic [NW-1:0]         warn_raw;

  // one wait state: pready rises in the second access cycle
  wire logic acc_req  = psel_in && penable_in && !pready_out;
  wire logic acc_done = psel_in && penable_in && pready_out;
  wire logic wr_done  = acc_done && pwrite_in;
  wire logic signed [DW-1:0] wdata = $signed(pwdata_in);

  wire logic wr_ctrl     = wr_done && (paddr_in == rflw_pkg::OFF_CTRL);
  wire logic wr_route    = wr_done && (paddr_in == rflw_pkg::OFF_ROUTE);
  wire logic wr_ref_low  = wr_done && (paddr_in == rflw_pkg::OFF_REF_LOW);
  wire logic wr_ref_high = wr_done && (paddr_in == rflw_pkg::OFF_REF_HIGH);
  wire logic wr_feedback_low_limit   = wr_done && (paddr_in == rflw_pkg::OFF_FEEDBACK_LOW_LIMIT);
  wire logic wr_feedback_high_limit  = wr_done && (paddr_in == rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT);
  wire logic restore     = wr_ctrl && pwdata_in[rflw_pkg::CTRL_DEFAULTS_BIT];

  always_comb begin
    rd_word  = '0;
    addr_hit = 1'b1;
    if (paddr_in == rflw_pkg::OFF_CTRL) begin
      rd_word[rflw_pkg::CTRL_LOOP_BIT]   = loop_mode;
      rd_word[rflw_pkg::CTRL_REMOTE_BIT] = remote_sel;
    end else if (paddr_in == rflw_pkg::OFF_ROUTE) begin
      rd_word = route;
    end else if (paddr_in == rflw_pkg::OFF_REF_LOW) begin
      rd_word = ref_low;
    end else if (paddr_in == rflw_pkg::OFF_REF_HIGH) begin
      rd_word = ref_high;
    end else if (paddr_in == rflw_pkg::OFF_FEEDBACK_LOW_LIMIT) begin
      rd_word = feedback_low_limit;
    end else if (paddr_in == rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT) begin
      rd_word = feedback_high_limit;
    end else if (paddr_in == rflw_pkg::OFF_STATUS) begin
      rd_word = status_word;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= acc_req;
      pslverr_out <= acc_req && !addr_hit;
      prdata_out  <= (acc_req && !pwrite_in) ? rd_word : '0;
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      loop_mode  <= rflw_pkg::loop_open;
      remote_sel <= 1'b1;
      route      <= rflw_pkg::ROUTE_RESET;
    end else begin
      if (wr_ctrl) begin
        loop_mode  <= rflw_pkg::rflw_loop_t'(pwdata_in[rflw_pkg::CTRL_LOOP_BIT]); // [R12]
        remote_sel <= pwdata_in[rflw_pkg::CTRL_REMOTE_BIT];
      end
      if (wr_route) begin
        route <= pwdata_in;
      end
    end
  end

  // each limit is clamped against its partner so low never passes high
  always_ff @(posedge mclk_in) begin
    if (srst_in || restore) begin
      ref_low             <= rflw_pkg::LIMIT_MIN; // [R10]
      ref_high            <= rflw_pkg::LIMIT_MAX; // [R10]
      feedback_low_limit  <= rflw_pkg::LIMIT_MIN;
      feedback_high_limit <= rflw_pkg::LIMIT_MAX;
    end else begin
      if (wr_ref_low) begin
        ref_low <= clamp(wdata, rflw_pkg::LIMIT_MIN, ref_high); // [R1]
      end
      if (wr_ref_high) begin
        ref_high <= clamp(wdata, ref_low, rflw_pkg::LIMIT_MAX); // [R2]
      end
      if (wr_feedback_low_limit) begin
        feedback_low_limit <= clamp(wdata, rflw_pkg::LIMIT_MIN, feedback_high_limit); // [R3]
      end
      if (wr_feedback_high_limit) begin
        feedback_high_limit <= clamp(wdata, feedback_low_limit, rflw_pkg::LIMIT_MAX); // [R4] [R9]
      end
    end
  end

  // --------------------------------------------------------------------------
  // run state and suppression
  // --------------------------------------------------------------------------
  rflw_pkg::rflw_state_t state;
  rflw_pkg::rflw_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      rflw_pkg::st_stopped: begin
        if (run_cmd_in) begin
          next_state = rflw_pkg::st_ramp_up;
        end
      end
      rflw_pkg::st_ramp_up: begin
        if (!run_cmd_in) begin
          next_state = rflw_pkg::st_ramp_down;
        end else if (at_ref_in) begin
          next_state = rflw_pkg::st_active; // [R6]
        end
      end
      rflw_pkg::st_active: begin
        if (!run_cmd_in) begin
          next_state = rflw_pkg::st_ramp_down; // [R5]
        end
      end
      rflw_pkg::st_ramp_down: begin
        if (run_cmd_in) begin
          next_state = rflw_pkg::st_ramp_up;
        end else if (drive_stopped_in) begin
          next_state = rflw_pkg::st_stopped;
        end
      end
      default: begin
        next_state = rflw_pkg::st_stopped;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= rflw_pkg::st_stopped;
    end else begin
      state <= next_state;
    end
  end

  wire logic eval     = (state == rflw_pkg::st_active); // [R5] [R6]
  wire logic ref_eval = eval && remote_sel;             // [R8]

  // --------------------------------------------------------------------------
  // comparators
  // --------------------------------------------------------------------------
  // limits are plain numbers; the unit follows the loop mode
  rflw_limit_cmp #(.W(DW)) u_ref_cmp (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .eval_in       (ref_eval),
    .low_val_in    (remote_ref_in),
    .high_val_in   (result_ref_in),
    .low_limit_in  (ref_low),
    .high_limit_in (ref_high),
    .low_warn_out  (warn_raw[rflw_pkg::WARN_REF_LOW]),
    .high_warn_out (warn_raw[rflw_pkg::WARN_REF_HIGH])
  );

  rflw_limit_cmp #(.W(DW)) u_fb_cmp (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .eval_in       (eval),
    .low_val_in    (feedback_in),
    .high_val_in   (feedback_in),
    .low_limit_in  (feedback_low_limit),
    .high_limit_in (feedback_high_limit),
    .low_warn_out  (warn_raw[rflw_pkg::WARN_FEEDBACK_LOW_LIMIT]),
    .high_warn_out (warn_raw[rflw_pkg::WARN_FEEDBACK_HIGH_LIMIT])
  );

  assign warn_out = warn_raw;

  always_comb begin
    status_word = '0;
    status_word[NW-1:0] = warn_raw;
    status_word[rflw_pkg::STAT_EVAL_BIT] = eval;
    status_word[rflw_pkg::STAT_LOOP_BIT] = loop_mode;
  end

  // --------------------------------------------------------------------------
  // output routing
  // --------------------------------------------------------------------------
  logic [rflw_pkg::NUM_ROUTE-1:0] route_hit;

  generate
    for (genvar i = 0; i < rflw_pkg::NUM_ROUTE; i++) begin : g_route
      assign route_hit[i] = |(route[i*NW +: NW] & warn_raw); // [R7]
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sig_out     <= '0;
      relay_out   <= '0;
      unit_hz_out <= 1'b1;
    end else begin
      sig_out     <= route_hit[rflw_pkg::NUM_SIG_OUT-1:0]; // [R7]
      relay_out   <= route_hit[rflw_pkg::NUM_ROUTE-1:rflw_pkg::NUM_SIG_OUT];
      unit_hz_out <= (loop_mode == rflw_pkg::loop_open); // [R11]
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_warn_suppressed: assert property ( // [R5]
    @(posedge mclk_in) disable iff (srst_in)
    (state != rflw_pkg::st_active) |=> (warn_out == '0))
    else $error("warning raised outside active state");

  a_eval_after_ref: assert property ( // [R6]
    @(posedge mclk_in) disable iff (srst_in)
    (state == rflw_pkg::st_ramp_up && run_cmd_in && at_ref_in)
      |=> (state == rflw_pkg::st_active))
    else $error("evaluation not enabled at reference");

  a_route_sig0: assert property ( // [R7]
    @(posedge mclk_in) disable iff (srst_in)
    (|(route[NW-1:0] & warn_out)) |=> sig_out[0])
    else $error("routed warning missing on signal output");

  a_ref_local_off: assert property ( // [R8]
    @(posedge mclk_in) disable iff (srst_in)
    !remote_sel |=> !warn_out[rflw_pkg::WARN_REF_LOW] && !warn_out[rflw_pkg::WARN_REF_HIGH])
    else $error("reference warning while local reference");

  a_feedback_high_limit_order: assert property ( // [R9]
    @(posedge mclk_in) disable iff (srst_in)
    feedback_high_limit >= feedback_low_limit && feedback_high_limit <= rflw_pkg::LIMIT_MAX)
    else $error("feedback high limit out of range");

  a_ref_low_order: assert property ( // [R1]
    @(posedge mclk_in) disable iff (srst_in)
    ref_low <= ref_high && ref_low >= rflw_pkg::LIMIT_MIN)
    else $error("reference low limit out of range");

  a_restore_limits: assert property ( // [R10]
    @(posedge mclk_in) disable iff (srst_in)
    restore |=> ref_high == rflw_pkg::LIMIT_MAX && ref_low == rflw_pkg::LIMIT_MIN)
    else $error("defaults not restored");

  a_loop_decode: assert property ( // [R12]
    @(posedge mclk_in) disable iff (srst_in)
    wr_ctrl |=> ##1 (unit_hz_out == !$past(pwdata_in[rflw_pkg::CTRL_LOOP_BIT], 2)))
    else $error("loop selector decoded wrongly");

  c_reach_active: cover property (
    @(posedge mclk_in) disable iff (srst_in)
    state == rflw_pkg::st_ramp_up ##1 state == rflw_pkg::st_active);

  c_ref_low_warn: cover property (
    @(posedge mclk_in) disable iff (srst_in) warn_out[rflw_pkg::WARN_REF_LOW]);

  c_feedback_high_limit_relay: cover property (
    @(posedge mclk_in) disable iff (srst_in)
    warn_out[rflw_pkg::WARN_FEEDBACK_HIGH_LIMIT] ##1 relay_out[0]);

  c_restore: cover property (
    @(posedge mclk_in) disable iff (srst_in) restore);

endmodule // rflw_monitor

/* verilog/rflw_pkg.sv */
package rflw_pkg;

  // --------------------------------------------------------------------------
  // data path
  // --------------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // limits are signed thousandths of the selected unit
  localparam logic signed [DATA_W-1:0] LIMIT_MAX = 32'sh3b9ac9ff;
  localparam logic signed [DATA_W-1:0] LIMIT_MIN = 32'shc4653601;

  // --------------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ROUTE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_REF_LOW  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REF_HIGH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_FEEDBACK_LOW_LIMIT   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FEEDBACK_HIGH_LIMIT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h18;

  // --------------------------------------------------------------------------
  // fields
  // --------------------------------------------------------------------------
  localparam int unsigned CTRL_LOOP_BIT     = 0;
  localparam int unsigned CTRL_REMOTE_BIT   = 1;
  localparam int unsigned CTRL_DEFAULTS_BIT = 2;
  localparam int unsigned STAT_EVAL_BIT     = 4;
  localparam int unsigned STAT_LOOP_BIT     = 5;

  localparam int unsigned NUM_WARN      = 4;
  localparam int unsigned WARN_REF_LOW  = 0;
  localparam int unsigned WARN_REF_HIGH = 1;
  localparam int unsigned WARN_FEEDBACK_LOW_LIMIT   = 2;
  localparam int unsigned WARN_FEEDBACK_HIGH_LIMIT  = 3;

  // route: one 4-bit warning mask per output, signal outputs first
  localparam int unsigned NUM_SIG_OUT = 2;
  localparam int unsigned NUM_RELAY   = 2;
  localparam int unsigned NUM_ROUTE   = NUM_SIG_OUT + NUM_RELAY;
  localparam logic [DATA_W-1:0] ROUTE_RESET = 32'h0000_0000;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic {
    loop_open   = 1'b0,
    loop_closed = 1'b1
  } rflw_loop_t;

  typedef enum logic [3:0] {
    st_stopped   = 4'h1,
    st_ramp_up   = 4'h2,
    st_active    = 4'h4,
    st_ramp_down = 4'h8
  } rflw_state_t;

endpackage

/* verilog/rflw_limit_cmp.sv */
`timescale 1ns/10ps
module rflw_limit_cmp #(
  parameter int W = rflw_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                mclk_in,
  input  wire logic                srst_in,
  // compare request
  input  wire logic                eval_in,
  input  wire logic signed [W-1:0] low_val_in,
  input  wire logic signed [W-1:0] high_val_in,
  input  wire logic signed [W-1:0] low_limit_in,
  input  wire logic signed [W-1:0] high_limit_in,
  // warnings
  output logic                     low_warn_out,
  output logic                     high_warn_out
);

  wire logic below = low_val_in < low_limit_in;
  wire logic above = high_val_in > high_limit_in;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      low_warn_out  <= 1'b0;
      high_warn_out <= 1'b0;
    end else begin
      low_warn_out  <= eval_in && below; // [R1] [R3] [R13]
      high_warn_out <= eval_in && above; // [R2] [R4] [R13]
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_low_warn_set: assert property ( // [R13]
    @(posedge mclk_in) disable iff (srst_in)
    (eval_in && low_val_in < low_limit_in) |=> low_warn_out)
    else $error("low warning missed");

  a_high_warn_clr: assert property ( // [R13]
    @(posedge mclk_in) disable iff (srst_in)
    (!eval_in || high_val_in <= high_limit_in) |=> !high_warn_out)
    else $error("high warning not cleared");

endmodule // rflw_limit_cmp

/* dv/rflw_monitor_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module rflw_monitor_bench;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic               mclk_in;
  logic               srst_in;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata_out;
  logic               pready_out;
  logic               pslverr_out;
  logic               run_cmd;
  logic               at_ref;
  logic               drive_stopped;
  logic signed [31:0] remote_ref;
  logic signed [31:0] result_ref;
  logic signed [31:0] feedback;
  logic [3:0]         warn_out;
  logic [1:0]         sig_out;
  logic [1:0]         relay_out;
  logic               unit_hz_out;
  int                 miscompares;
  int                 checks_done;

  rflw_monitor u_rflw_monitor (
    .mclk_in(mclk_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .run_cmd_in(run_cmd),
    .at_ref_in(at_ref), .drive_stopped_in(drive_stopped), .remote_ref_in(remote_ref),
    .result_ref_in(result_ref), .feedback_in(feedback), .warn_out(warn_out),
    .sig_out(sig_out), .relay_out(relay_out), .unit_hz_out(unit_hz_out)
  );

  // --------------------------------------------------------------------------
  // clock, reset, watchdog
  // --------------------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // generous against the few hundred cycles the scenarios need
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // apb master
  // --------------------------------------------------------------------------
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
    int n;
    @(posedge mclk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rdata = prdata_out;
    err   = pslverr_out;
    psel    <= 1'b0;
    penable <= 1'b0;
    `CHK("apb answer", 1'b1, pready_out)
    // a slave that never answers ends the run at once, as a failure
    if (pready_out !== 1'b1) begin
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b1, addr, data, d, e);
    `CHK("write error", 1'b0, e)
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b0, addr, 32'h0, d, e);
    `CHK(nm, exp, d)
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk_in);
  endtask

  task automatic chk_out(input logic [3:0] w, input logic [1:0] s, input logic [1:0] r);
    `CHK("warn_out", w, warn_out)
    `CHK("sig_out", s, sig_out)
    `CHK("relay_out", r, relay_out)
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_map();
    logic [31:0] d;
    logic        e;
    rd_chk(rflw_pkg::OFF_REF_LOW, rflw_pkg::LIMIT_MIN, "ref low");
    rd_chk(rflw_pkg::OFF_REF_HIGH, rflw_pkg::LIMIT_MAX, "ref high");
    rd_chk(rflw_pkg::OFF_FEEDBACK_LOW_LIMIT, rflw_pkg::LIMIT_MIN, "feedback_low_limit");
    rd_chk(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, rflw_pkg::LIMIT_MAX, "feedback_high_limit");
    rd_chk(rflw_pkg::OFF_CTRL, 32'h0000_0002, "ctrl");
    rd_chk(rflw_pkg::OFF_ROUTE, rflw_pkg::ROUTE_RESET, "route");
    `CHK("unit_hz", 1'b1, unit_hz_out)
    chk_out(4'h0, 2'h0, 2'h0);
    apb_xfer(1'b0, 8'h1c, 32'h0, d, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, d)
  endtask

  task automatic t_clamp_restore();
    wr(rflw_pkg::OFF_FEEDBACK_LOW_LIMIT, 32'hc000_0000);
    rd_chk(rflw_pkg::OFF_FEEDBACK_LOW_LIMIT, rflw_pkg::LIMIT_MIN, "feedback_low_limit floor");
    wr(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, 32'h7fff_ffff);
    rd_chk(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, rflw_pkg::LIMIT_MAX, "feedback_high_limit cap");
    wr(rflw_pkg::OFF_FEEDBACK_LOW_LIMIT, 32'h0000_03e8);
    wr(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, 32'h0000_01f4);
    rd_chk(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, 32'h0000_03e8, "feedback_high_limit floor");
    wr(rflw_pkg::OFF_REF_HIGH, 32'h0000_0064);
    wr(rflw_pkg::OFF_REF_LOW, 32'h0000_00c8);
    rd_chk(rflw_pkg::OFF_REF_LOW, 32'h0000_0064, "ref low cap");
    wr(rflw_pkg::OFF_CTRL, 32'h0000_0006);
    rd_chk(rflw_pkg::OFF_REF_LOW, rflw_pkg::LIMIT_MIN, "ref low def");
    rd_chk(rflw_pkg::OFF_REF_HIGH, rflw_pkg::LIMIT_MAX, "ref high def");
    rd_chk(rflw_pkg::OFF_CTRL, 32'h0000_0002, "ctrl after restore");
  endtask

  task automatic t_loop_mode();
    wr(rflw_pkg::OFF_CTRL, 32'h0000_0003);
    settle();
    `CHK("unit_hz closed", 1'b0, unit_hz_out)
    rd_chk(rflw_pkg::OFF_STATUS, 32'h0000_0020, "status closed");
    wr(rflw_pkg::OFF_CTRL, 32'h0000_0002);
    settle();
    `CHK("unit_hz open", 1'b1, unit_hz_out)
  endtask

  task automatic t_warnings();
    wr(rflw_pkg::OFF_REF_LOW, 32'hffff_fc18);
    wr(rflw_pkg::OFF_REF_HIGH, 32'h0000_03e8);
    wr(rflw_pkg::OFF_FEEDBACK_LOW_LIMIT, 32'hffff_f830);
    wr(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, 32'h0000_07d0);
    wr(rflw_pkg::OFF_ROUTE, 32'h0000_4281);
    @(posedge mclk_in);
    remote_ref <= -32'sd1001;
    result_ref <= 32'sd1001;
    feedback   <= 32'sd2001;
    settle();
    chk_out(4'h0, 2'h0, 2'h0);
    run_cmd <= 1'b1;
    settle();
    chk_out(4'h0, 2'h0, 2'h0);
    at_ref <= 1'b1;
    settle();
    chk_out(4'hb, 2'h3, 2'h1);
    rd_chk(rflw_pkg::OFF_STATUS, 32'h0000_001b, "status active");
    feedback <= -32'sd2001;
    settle();
    chk_out(4'h7, 2'h1, 2'h3);
    remote_ref <= -32'sd1000;
    result_ref <= 32'sd1000;
    feedback   <= -32'sd2000;
    settle();
    chk_out(4'h0, 2'h0, 2'h0);
    remote_ref <= -32'sd1001;
    result_ref <= 32'sd1001;
    feedback   <= -32'sd2001;
    wr(rflw_pkg::OFF_CTRL, 32'h0000_0000);
    settle();
    chk_out(4'h4, 2'h0, 2'h2);
    wr(rflw_pkg::OFF_CTRL, 32'h0000_0002);
    run_cmd <= 1'b0;
    settle();
    chk_out(4'h0, 2'h0, 2'h0);
    drive_stopped <= 1'b1;
    settle();
    chk_out(4'h0, 2'h0, 2'h0);
  endtask

  // reset in mid-run, with a warning standing and the drive running
  task automatic t_mid_reset();
    wr(rflw_pkg::OFF_CTRL, 32'h0000_0001);
    wr(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, 32'h0000_0000);
    feedback      <= 32'sd1;
    drive_stopped <= 1'b0;
    run_cmd       <= 1'b1;
    settle();
    settle();
    chk_out(4'h8, 2'h2, 2'h0);
    srst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    chk_out(4'h0, 2'h0, 2'h0);
    `CHK("unit_hz reset", 1'b1, unit_hz_out)
    rd_chk(rflw_pkg::OFF_FEEDBACK_HIGH_LIMIT, rflw_pkg::LIMIT_MAX, "feedback_high_limit reset");
    rd_chk(rflw_pkg::OFF_CTRL, 32'h0000_0002, "ctrl reset");
    settle();
    chk_out(4'h0, 2'h0, 2'h0);
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    miscompares   = 0;
    checks_done   = 0;
    srst_in       = 1'b1;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    run_cmd       = 1'b0;
    at_ref        = 1'b0;
    drive_stopped = 1'b0;
    remote_ref    = 32'sd0;
    result_ref    = 32'sd0;
    feedback      = 32'sd0;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset_map();
    t_clamp_restore();
    t_loop_mode();
    t_warnings();
    t_mid_reset();
    finish_test();
  end
endmodule // rflw_monitor_bench
